// ### touch_key_pkg.sv
// Shared constants and types for the touch keypad controller
package touch_key_pkg;

	// Clock rate in kHz; cycle counts below are derived from it
	localparam int unsigned CLK_KHZ      = 10_000;

	// Documented times in milliseconds
	localparam int unsigned LED_ON_MS    = 5000;
	localparam int unsigned SOFT_OFF_MS  = 3000;
	localparam int unsigned HARD_OFF_MS  = 6000;
	localparam int unsigned PWR_ON_MS    = 1000;
	localparam int unsigned DEBOUNCE_MS  = 20;

	// Cycle counts derived from the times above
	localparam int unsigned LED_ON_CYC   = CLK_KHZ * LED_ON_MS;
	localparam int unsigned SOFT_OFF_CYC = CLK_KHZ * SOFT_OFF_MS;
	localparam int unsigned HARD_OFF_CYC = CLK_KHZ * HARD_OFF_MS;
	localparam int unsigned PWR_ON_CYC   = CLK_KHZ * PWR_ON_MS;
	localparam int unsigned DEBOUNCE_CYC = CLK_KHZ * DEBOUNCE_MS;

	// Brightness range
	localparam logic [3:0] LEVEL_MAX     = 4'hA;
	localparam logic [3:0] LEVEL_RST     = 4'h5;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h04;
	localparam logic [7:0] OFS_LEVEL     = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;

	// Control register fields
	localparam int unsigned CTRL_FUNC_LSB = 0;
	localparam int unsigned CTRL_AUTO_BIT = 2;
	localparam logic [2:0]  CTRL_RST      = 3'h0;

	// Status register fields
	localparam int unsigned ST_S0_BIT     = 0;
	localparam int unsigned ST_ARMED_BIT  = 1;
	localparam int unsigned ST_TOUCH_BIT  = 2;
	localparam int unsigned ST_HOLD_BIT   = 3;
	localparam int unsigned ST_LEVEL_LSB  = 4;

	// Event bits, shared by interrupt status and mask
	localparam int unsigned EV_PWR_ON     = 0;
	localparam int unsigned EV_SOFT_OFF   = 1;
	localparam int unsigned EV_HARD_OFF   = 2;
	localparam int unsigned EV_CUSTOM     = 3;
	localparam int unsigned EV_TOUCH      = 4;
	localparam int unsigned EV_LEVEL      = 5;
	localparam int unsigned EV_W          = 6;
	localparam logic [5:0]  IRQ_MASK_RST  = 6'h00;

	// Key index within the key vector
	localparam int unsigned KEY_MF        = 0;
	localparam int unsigned KEY_UP        = 1;
	localparam int unsigned KEY_DN        = 2;
	localparam int unsigned KEY_N         = 3;

	// Multi-function key assignment
	typedef enum logic [1:0] {
		FN_POWER  = 2'b00,
		FN_TOUCH  = 2'b01,
		FN_CUSTOM = 2'b10
	} mf_func_e;

	// Power key hold tracker
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_S0   = 2'b01,
		H_S5   = 2'b10,
		H_DONE = 2'b11
	} hold_e;

endpackage

// ### key_debounce.sv
// Synchroniser and debouncer for one touch key input
`timescale 1ns/1ns
`default_nettype none

module key_debounce #(
	parameter int unsigned CYC = 200000,
	parameter int unsigned W   = 18
) (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rstn_i,
	// Raw key level from the pad
	input  wire logic raw_i,
	// Debounced level and its edges
	output logic      level_o,
	output logic      press_o,
	output logic      release_o
);

	logic         meta_r;
	logic         sync_r;
	logic [W-1:0] cnt_r;

	// Two flip-flops before anything reads the pad
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end
		else
		begin
			meta_r <= raw_i;
			sync_r <= meta_r;
		end
	end

	// Level flips only after the input stays changed for CYC cycles
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cnt_r     <= '0;
			level_o   <= 1'b0;
			press_o   <= 1'b0;
			release_o <= 1'b0;
		end
		else
		begin
			press_o   <= 1'b0;
			release_o <= 1'b0;
			if (sync_r == level_o)
				cnt_r <= '0;
			else if (cnt_r == W'(CYC - 1))
			begin
				cnt_r     <= '0;
				level_o   <= sync_r;
				press_o   <= sync_r;
				release_o <= ~sync_r;
			end
			else
				cnt_r <= cnt_r + 1'b1;
		end
	end

endmodule

`default_nettype wire

// ### touch_key_ctrl.sv
// Touch keypad controller: arming, power key timing, backlight and APB registers
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - In the working state a first press only arms the keypad and lights all three key LEDs; a press while armed runs the key's function.
// - While the host is in soft-off the multi-function key LED stays dark.
// - In the working state a touch lights the multi-function key LED green for 5 seconds.
// - The multi-function key acts as power key, touch toggle or custom action, power key after reset.
// - In soft-off the multi-function key always acts as the power key.
// - In the working state a 3 second hold of the power key requests an orderly shutdown.
// - In the working state a 6 second hold of the power key forces a hard shutdown at once.
// - In soft-off a 1 second hold of the power key requests power-on.
// - Touch enable is set after reset and each activating press of the touch toggle key inverts it.
// - In the working state a touch lights both brightness key LEDs white for 5 seconds.
// - With auto light sensing off, a manual brightness level 0 to 10 is stepped by the brightness keys.
module touch_key_ctrl #(
	parameter int unsigned CNT_W        = 26,
	parameter int unsigned DEB_W        = 18,
	parameter int unsigned LED_ON_CYC   = touch_key_pkg::LED_ON_CYC,
	parameter int unsigned SOFT_OFF_CYC = touch_key_pkg::SOFT_OFF_CYC,
	parameter int unsigned HARD_OFF_CYC = touch_key_pkg::HARD_OFF_CYC,
	parameter int unsigned PWR_ON_CYC   = touch_key_pkg::PWR_ON_CYC,
	parameter int unsigned DEBOUNCE_CYC = touch_key_pkg::DEBOUNCE_CYC
) (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rstn_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Touch keys and host power state pins
	input  wire logic        key_mf_i,
	input  wire logic        key_up_i,
	input  wire logic        key_dn_i,
	input  wire logic        host_s0_i,
	// Key backlight LEDs
	output logic             led_mf_green_o,
	output logic             led_up_white_o,
	output logic             led_dn_white_o,
	// Requests to the host platform
	output logic             pwr_on_req_o,
	output logic             soft_off_req_o,
	output logic             hard_off_o,
	output logic             custom_act_o,
	output logic             touch_en_o,
	output logic      [3:0]  bright_level_o,
	// Interrupt
	output logic             irq_o
);

	localparam int unsigned EW = touch_key_pkg::EV_W;
	localparam int unsigned KN = touch_key_pkg::KEY_N;

	// Map the raw function field; the unused code falls back to the power key
	function automatic touch_key_pkg::mf_func_e decode_func(input logic [1:0] f);
		touch_key_pkg::mf_func_e r;
		r = touch_key_pkg::FN_POWER;
		if (f == 2'b01)
			r = touch_key_pkg::FN_TOUCH;
		else if (f == 2'b10)
			r = touch_key_pkg::FN_CUSTOM;
		return r;
	endfunction

	// Register offset match, shared by setup decode and write strobes
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	logic                    s0_meta_r;
	logic                    s0_r;
	logic [KN-1:0]           key_raw;
	logic [KN-1:0]           key_lvl;
	logic [KN-1:0]           key_press;
	logic [KN-1:0]           key_rel;
	logic [KN-1:0]           act_press;
	logic [CNT_W-1:0]        led_cnt_r;
	logic                    armed;
	logic [2:0]              ctrl_r;
	logic                    auto_light;
	touch_key_pkg::mf_func_e func_eff;
	touch_key_pkg::hold_e    hold_r;
	touch_key_pkg::hold_e    hold_nxt;
	logic [CNT_W-1:0]        hold_cnt_r;
	logic                    touch_en_r;
	logic [3:0]              level_r;
	logic [EW-1:0]           ev_nxt;
	logic [EW-1:0]           ev_r;
	logic [EW-1:0]           irq_stat_r;
	logic [EW-1:0]           irq_mask_r;
	logic                    irq_r;
	logic                    wr_en;
	logic                    setup;
	logic                    bad_r;
	logic [31:0]             rd_mux;
	logic [31:0]             prdata_r;

	// Host power state pin is asynchronous: two flops before use
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			s0_meta_r <= 1'b0;
			s0_r      <= 1'b0;
		end
		else
		begin
			s0_meta_r <= host_s0_i;
			s0_r      <= s0_meta_r;
		end
	end

	// One debouncer per key; hold timing relies on the clean level
	assign key_raw = {key_dn_i, key_up_i, key_mf_i};

	genvar g;
	generate
		for (g = 0; g < KN; g++)
		begin : g_key
			key_debounce #(
				.CYC (DEBOUNCE_CYC),
				.W   (DEB_W)
			) u_deb (
				.ref_clk_i (ref_clk_i),
				.rstn_i    (rstn_i),
				.raw_i     (key_raw[g]),
				.level_o   (key_lvl[g]),
				.press_o   (key_press[g]),
				.release_o (key_rel[g])
			);
		end
	endgenerate

	// Backlight timer: any touch in S0 restarts the 5 s window
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			led_cnt_r <= '0;
		else if (!s0_r)
			led_cnt_r <= '0;
		else if (|key_press)
			led_cnt_r <= CNT_W'(LED_ON_CYC);
		else if (led_cnt_r != '0)
			led_cnt_r <= led_cnt_r - 1'b1;
	end

	// Armed exactly while the indication is lit
	assign armed = (led_cnt_r != '0);

	// Only presses that arrive while armed run a function
	assign act_press = key_press & {KN{armed & s0_r}};

	// Control register fields
	assign auto_light = ctrl_r[touch_key_pkg::CTRL_AUTO_BIT];

	// Soft-off forces the power key whatever was configured
	always_comb
	begin
		if (!s0_r)
			func_eff = touch_key_pkg::FN_POWER;
		else
			func_eff = decode_func(ctrl_r[touch_key_pkg::CTRL_FUNC_LSB +: 2]);
	end

	// Power key hold tracker and event generation
	always_comb
	begin
		hold_nxt = hold_r;
		ev_nxt   = '0;
		unique case (hold_r)
			touch_key_pkg::H_IDLE:
			begin
				// In soft-off no arming is needed so the system can always start
				if (!s0_r && key_press[touch_key_pkg::KEY_MF])
					hold_nxt = touch_key_pkg::H_S5;
				else if (act_press[touch_key_pkg::KEY_MF] && func_eff == touch_key_pkg::FN_POWER)
					hold_nxt = touch_key_pkg::H_S0;
			end
			touch_key_pkg::H_S0:
			begin
				// Host left the working state mid-hold: no shutdown request from soft-off
				if (!s0_r)
					hold_nxt = touch_key_pkg::H_DONE;
				else if (key_rel[touch_key_pkg::KEY_MF])
				begin
					hold_nxt = touch_key_pkg::H_IDLE;
					if (hold_cnt_r >= CNT_W'(SOFT_OFF_CYC))
						ev_nxt[touch_key_pkg::EV_SOFT_OFF] = 1'b1;
				end
				else if (hold_cnt_r >= CNT_W'(HARD_OFF_CYC - 1))
				begin
					hold_nxt = touch_key_pkg::H_DONE;
					ev_nxt[touch_key_pkg::EV_HARD_OFF] = 1'b1;
				end
			end
			touch_key_pkg::H_S5:
			begin
				if (key_rel[touch_key_pkg::KEY_MF])
				begin
					hold_nxt = touch_key_pkg::H_IDLE;
					if (hold_cnt_r >= CNT_W'(PWR_ON_CYC))
						ev_nxt[touch_key_pkg::EV_PWR_ON] = 1'b1;
				end
				else if (s0_r)
					hold_nxt = touch_key_pkg::H_DONE; // Host woke by other means
			end
			touch_key_pkg::H_DONE:
			begin
				// Swallow the rest of the hold so release does nothing
				if (!key_lvl[touch_key_pkg::KEY_MF])
					hold_nxt = touch_key_pkg::H_IDLE;
			end
		endcase
		if (act_press[touch_key_pkg::KEY_MF] && func_eff == touch_key_pkg::FN_CUSTOM)
			ev_nxt[touch_key_pkg::EV_CUSTOM] = 1'b1;
		if (act_press[touch_key_pkg::KEY_MF] && func_eff == touch_key_pkg::FN_TOUCH)
			ev_nxt[touch_key_pkg::EV_TOUCH] = 1'b1;
		if (!auto_light && ((act_press[touch_key_pkg::KEY_UP] && level_r != touch_key_pkg::LEVEL_MAX)
			|| (act_press[touch_key_pkg::KEY_DN] && level_r != 4'h0)))
			ev_nxt[touch_key_pkg::EV_LEVEL] = 1'b1;
	end

	// Hold state register
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			hold_r <= touch_key_pkg::H_IDLE;
		else
			hold_r <= hold_nxt;
	end

	// Hold length counter, reloaded with 1 while idle so each new hold starts from 1, and saturating
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			hold_cnt_r <= '0;
		else if (hold_r == touch_key_pkg::H_IDLE)
			hold_cnt_r <= CNT_W'(1);
		else if (hold_cnt_r != '1)
			hold_cnt_r <= hold_cnt_r + 1'b1;
	end

	// Touch enable flag: set at reset, toggled by the touch key function
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			touch_en_r <= 1'b1;
		else if (ev_nxt[touch_key_pkg::EV_TOUCH])
			touch_en_r <= ~touch_en_r;
	end

	// Manual brightness; software writes are clamped to the top level
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			level_r <= touch_key_pkg::LEVEL_RST;
		else if (wr_en && hit(paddr_i, touch_key_pkg::OFS_LEVEL))
		begin
			if (pwdata_i[3:0] > touch_key_pkg::LEVEL_MAX)
				level_r <= touch_key_pkg::LEVEL_MAX;
			else
				level_r <= pwdata_i[3:0];
		end
		else if (!auto_light)
		begin
			// Up wins when both keys land in the same cycle, except at level ten, where down steps
			if (act_press[touch_key_pkg::KEY_UP] && level_r != touch_key_pkg::LEVEL_MAX)
				level_r <= level_r + 4'h1;
			else if (act_press[touch_key_pkg::KEY_DN] && level_r != 4'h0)
				level_r <= level_r - 4'h1;
		end
	end

	// Event pulses to the host are registered for clean one-cycle strobes
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			ev_r <= '0;
		else
			ev_r <= ev_nxt;
	end

	// Control register
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			ctrl_r <= touch_key_pkg::CTRL_RST;
		else if (wr_en && hit(paddr_i, touch_key_pkg::OFS_CTRL))
			ctrl_r <= pwdata_i[2:0];
	end

	// Sticky status: a new event beats a write-one-to-clear in the same cycle
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			irq_stat_r <= '0;
		else if (wr_en && hit(paddr_i, touch_key_pkg::OFS_IRQ_STAT))
			irq_stat_r <= (irq_stat_r & ~pwdata_i[EW-1:0]) | ev_nxt;
		else
			irq_stat_r <= irq_stat_r | ev_nxt;
	end

	// Interrupt mask
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			irq_mask_r <= touch_key_pkg::IRQ_MASK_RST;
		else if (wr_en && hit(paddr_i, touch_key_pkg::OFS_IRQ_MASK))
			irq_mask_r <= pwdata_i[EW-1:0];
	end

	// Interrupt level is registered, so it trails the status by one cycle
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			irq_r <= 1'b0;
		else
			irq_r <= |(irq_stat_r & irq_mask_r);
	end

	// APB phases; the slave never inserts wait states
	assign setup = psel_i & ~penable_i;
	assign wr_en = psel_i & penable_i & pwrite_i & ~bad_r;

	// Read mux, sampled in the setup phase
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (hit(paddr_i, touch_key_pkg::OFS_CTRL))
			rd_mux[2:0] = ctrl_r;
		else if (hit(paddr_i, touch_key_pkg::OFS_STATUS))
		begin
			rd_mux[touch_key_pkg::ST_S0_BIT]    = s0_r;
			rd_mux[touch_key_pkg::ST_ARMED_BIT] = armed;
			rd_mux[touch_key_pkg::ST_TOUCH_BIT] = touch_en_r;
			rd_mux[touch_key_pkg::ST_HOLD_BIT]  = (hold_r != touch_key_pkg::H_IDLE);
			rd_mux[touch_key_pkg::ST_LEVEL_LSB +: 4] = level_r;
		end
		else if (hit(paddr_i, touch_key_pkg::OFS_LEVEL))
			rd_mux[3:0] = level_r;
		else if (hit(paddr_i, touch_key_pkg::OFS_IRQ_STAT))
			rd_mux[EW-1:0] = irq_stat_r;
		else if (hit(paddr_i, touch_key_pkg::OFS_IRQ_MASK))
			rd_mux[EW-1:0] = irq_mask_r;
	end

	// Capture read data and the decode error during setup, so both come from flops
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			prdata_r <= 32'h0000_0000;
			bad_r    <= 1'b0;
		end
		else if (setup)
		begin
			prdata_r <= pwrite_i ? 32'h0000_0000 : rd_mux;
			bad_r    <= ~(hit(paddr_i, touch_key_pkg::OFS_CTRL) | hit(paddr_i, touch_key_pkg::OFS_STATUS)
				| hit(paddr_i, touch_key_pkg::OFS_LEVEL) | hit(paddr_i, touch_key_pkg::OFS_IRQ_STAT)
				| hit(paddr_i, touch_key_pkg::OFS_IRQ_MASK));
		end
	end

	// Bus answers
	assign prdata_o  = prdata_r;
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & bad_r;

	// LEDs: all three follow the armed window, dark in soft-off
	assign led_mf_green_o = armed & s0_r;
	assign led_up_white_o = armed & s0_r;
	assign led_dn_white_o = armed & s0_r;

	// Host-side outputs
	assign pwr_on_req_o   = ev_r[touch_key_pkg::EV_PWR_ON];
	assign soft_off_req_o = ev_r[touch_key_pkg::EV_SOFT_OFF];
	assign hard_off_o     = ev_r[touch_key_pkg::EV_HARD_OFF];
	assign custom_act_o   = ev_r[touch_key_pkg::EV_CUSTOM];
	assign touch_en_o     = touch_en_r;
	assign bright_level_o = level_r;
	assign irq_o          = irq_r;

endmodule

`default_nettype wire

// ### touch_key_props.sv
// Port checker for the touch keypad controller
`timescale 1ns/1ns
`default_nettype none

module touch_key_props (
	// Clock and reset
	input wire logic        ref_clk_i,
	input wire logic        rstn_i,
	// APB
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	// Host state, LEDs and requests
	input wire logic        host_s0_i,
	input wire logic        led_mf_green_o,
	input wire logic        led_up_white_o,
	input wire logic        led_dn_white_o,
	input wire logic        pwr_on_req_o,
	input wire logic        soft_off_req_o,
	input wire logic        hard_off_o,
	input wire logic        custom_act_o,
	input wire logic [3:0]  bright_level_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);

	// Any request pulse
	wire logic any_req = pwr_on_req_o | soft_off_req_o | hard_off_o | custom_act_o;
	logic      wr_seen_r;

	// Bus writes may move the level by any amount, so remember the last write access
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			wr_seen_r <= 1'b0;
		else
			wr_seen_r <= psel_i & penable_i & pwrite_i;
	end

	// No wait states: every access is answered at once
	ready_tied_a: assert property (pready_o)
		else $error("pready low");
	err_decode_a: assert property (psel_i && penable_i && paddr_i[1:0] == 2'h0 |->
		pslverr_o == (paddr_i > touch_key_pkg::OFS_IRQ_MASK))
		else $error("slave error does not match the address");
	rd_zero_a: assert property (psel_i && penable_i && (pwrite_i || pslverr_o) |-> prdata_o == 32'h0)
		else $error("read data not zero");
	led_group_a: assert property (led_up_white_o == led_mf_green_o && led_dn_white_o == led_mf_green_o)
		else $error("key LEDs not lit together");
	// Synchronised host state needs a few edges before the LED must be dark
	s5_dark_a: assert property (!host_s0_i [*5] |-> !led_mf_green_o)
		else $error("key LED lit in soft-off");
	level_range_a: assert property (bright_level_o <= touch_key_pkg::LEVEL_MAX)
		else $error("level above ten");
	level_step_a: assert property ($changed(bright_level_o) && !wr_seen_r |->
		bright_level_o == $past(bright_level_o) + 4'h1 || bright_level_o == $past(bright_level_o) - 4'h1)
		else $error("level moved by more than one step");
	pulse_single_a: assert property (any_req |=> !any_req)
		else $error("request pulse longer than one cycle");
	s0_no_pwron_a: assert property (host_s0_i [*6] |-> !pwr_on_req_o)
		else $error("power-on request while working");
	s5_no_off_a: assert property (!host_s0_i [*6] |-> !soft_off_req_o && !hard_off_o)
		else $error("shutdown request in soft-off");
endmodule

bind touch_key_ctrl touch_key_props u_props (
	.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .host_s0_i(host_s0_i),
	.led_mf_green_o(led_mf_green_o), .led_up_white_o(led_up_white_o), .led_dn_white_o(led_dn_white_o),
	.pwr_on_req_o(pwr_on_req_o), .soft_off_req_o(soft_off_req_o), .hard_off_o(hard_off_o),
	.custom_act_o(custom_act_o), .bright_level_o(bright_level_o)
);

`default_nettype wire

// ### host_panel_model.sv
// Host platform and operator model facing the keypad controller
`timescale 1ns/1ns
`default_nettype none

module host_panel_model (
	// Clock
	input  wire logic ref_clk_i,
	// Requests from the controller
	input  wire logic pwr_on_req_i,
	input  wire logic soft_off_req_i,
	input  wire logic hard_off_i,
	// Keys and power state
	output logic      key_mf_o,
	output logic      key_up_o,
	output logic      key_dn_o,
	output logic      host_s0_o
);
	int         resp_dly = 20; // Lowered by the bench to model a prompt platform
	int         wait_cnt = 0;
	logic       next_s0  = 1'b1;
	logic [2:0] key_r    = 3'h0;

	assign key_mf_o = key_r[touch_key_pkg::KEY_MF];
	assign key_up_o = key_r[touch_key_pkg::KEY_UP];
	assign key_dn_o = key_r[touch_key_pkg::KEY_DN];

	initial host_s0_o = 1'b1;

	// Platform changes state after its delay; a forced shutdown cuts power almost at once
	always @(posedge ref_clk_i)
	begin
		if (hard_off_i || soft_off_req_i || pwr_on_req_i)
		begin
			next_s0 = pwr_on_req_i;
			wait_cnt = hard_off_i ? 1 : resp_dly;
		end
		else if (wait_cnt > 0)
		begin
			wait_cnt--;
			if (wait_cnt == 0)
				host_s0_o <= next_s0;
		end
	end

	// Operator touches a key, then stays off long enough for the release to be debounced
	task automatic press(input int k, input int hold);
		key_r[k] <= 1'b1;
		repeat (hold) @(posedge ref_clk_i);
		key_r[k] <= 1'b0;
		repeat (16) @(posedge ref_clk_i);
	endtask
endmodule

`default_nettype wire

// ### touch_key_ctrl_tb_top.sv
// Self-checking bench for the touch keypad controller
`timescale 1ns/1ns
`default_nettype none

module touch_key_ctrl_tb_top;
	localparam int unsigned LED_CYC = 200;
	localparam int unsigned LIMIT   = 5000;

	logic        clk     = 1'b0;
	logic        rstn    = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic [3:0]  level;
	logic        pready, pslverr, key_mf, key_up, key_dn, host_s0, err;
	logic        led_mf, led_up, led_dn, pwr_on, soft_off, hard_off, custom, touch_en, irq;
	logic        hard_held  = 1'b0;
	int          n_mismatch = 0;
	int          n_tests    = 0;
	int          n_pwr = 0, n_soft = 0, n_hard = 0, n_cust = 0, cycles = 0;

	always #50 clk = ~clk;

	touch_key_ctrl #(
		.LED_ON_CYC(LED_CYC), .SOFT_OFF_CYC(30), .HARD_OFF_CYC(60), .PWR_ON_CYC(10), .DEBOUNCE_CYC(4)
	) DUT (
		.ref_clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .key_mf_i(key_mf),
		.key_up_i(key_up), .key_dn_i(key_dn), .host_s0_i(host_s0), .led_mf_green_o(led_mf),
		.led_up_white_o(led_up), .led_dn_white_o(led_dn), .pwr_on_req_o(pwr_on), .soft_off_req_o(soft_off),
		.hard_off_o(hard_off), .custom_act_o(custom), .touch_en_o(touch_en), .bright_level_o(level), .irq_o(irq)
	);

	host_panel_model u_host (
		.ref_clk_i(clk), .pwr_on_req_i(pwr_on), .soft_off_req_i(soft_off), .hard_off_i(hard_off),
		.key_mf_o(key_mf), .key_up_o(key_up), .key_dn_o(key_dn), .host_s0_o(host_s0)
	);

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask

	// One APB transfer; the request holds until pready is seen high, then one idle edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// Request pulses stand one cycle, so each is counted at the edge that sees it; also the hang limit
	always @(posedge clk)
	begin
		cycles++;
		n_pwr += int'(pwr_on === 1'b1);
		n_soft += int'(soft_off === 1'b1);
		n_hard += int'(hard_off === 1'b1);
		n_cust += int'(custom === 1'b1);
		if (hard_off === 1'b1)
			hard_held = key_mf;
		if (cycles >= LIMIT)
		begin
			n_mismatch++;
			finish_test();
		end
	end

	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		// Reset state, register defaults and an unmapped place
		chk(touch_en, 1'b1);
		chk(level, touch_key_pkg::LEVEL_RST);
		chk(irq, 1'b0);
		apb(1'b0, touch_key_pkg::OFS_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, touch_key_pkg::OFS_IRQ_MASK, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		$display("test reset done");
		// First press only arms and lights all keys; the second steps the level and raises the interrupt
		apb(1'b1, touch_key_pkg::OFS_IRQ_MASK, 32'h20);
		u_host.press(touch_key_pkg::KEY_UP, 10);
		chk({led_mf, led_up, led_dn, level}, {3'h7, 4'h5});
		u_host.press(touch_key_pkg::KEY_UP, 10);
		chk({irq, level}, {1'b1, 4'h6});
		apb(1'b0, touch_key_pkg::OFS_IRQ_STAT, 32'h0);
		chk(rd, 32'h20);
		apb(1'b1, touch_key_pkg::OFS_IRQ_STAT, 32'h20);
		@(posedge clk);
		chk(irq, 1'b0);
		// Masked event still sets its status bit, which a one clears
		apb(1'b1, touch_key_pkg::OFS_IRQ_MASK, 32'h0);
		u_host.press(touch_key_pkg::KEY_DN, 10);
		chk({irq, level}, {1'b0, 4'h5});
		apb(1'b0, touch_key_pkg::OFS_IRQ_STAT, 32'h0);
		chk(rd, 32'h20);
		apb(1'b1, touch_key_pkg::OFS_IRQ_STAT, 32'h20);
		apb(1'b0, touch_key_pkg::OFS_IRQ_STAT, 32'h0);
		chk(rd, 32'h0);
		// Level saturates at ten, and keys leave it alone with auto light on
		apb(1'b1, touch_key_pkg::OFS_LEVEL, 32'hF);
		apb(1'b0, touch_key_pkg::OFS_LEVEL, 32'h0);
		chk(rd, 32'hA);
		u_host.press(touch_key_pkg::KEY_UP, 10);
		chk(level, 4'hA);
		apb(1'b1, touch_key_pkg::OFS_CTRL, 32'h4);
		u_host.press(touch_key_pkg::KEY_DN, 10);
		chk(level, 4'hA);
		apb(1'b1, touch_key_pkg::OFS_CTRL, 32'h0);
		$display("test level done");
		// After the lit window lapses, the next press arms again without acting
		repeat (LED_CYC + 20) @(posedge clk);
		chk(led_mf, 1'b0);
		u_host.press(touch_key_pkg::KEY_DN, 10);
		chk({led_mf, level}, {1'b1, 4'hA});
		apb(1'b0, touch_key_pkg::OFS_STATUS, 32'h0);
		chk(rd, 32'hA7);
		$display("test lapse done");
		// Multi-function key as touch toggle, then as custom action
		apb(1'b1, touch_key_pkg::OFS_CTRL, 32'h1);
		u_host.press(touch_key_pkg::KEY_MF, 10);
		chk(touch_en, 1'b0);
		u_host.press(touch_key_pkg::KEY_MF, 10);
		chk(touch_en, 1'b1);
		apb(1'b1, touch_key_pkg::OFS_CTRL, 32'h2);
		u_host.press(touch_key_pkg::KEY_MF, 10);
		chk(n_cust, 1);
		$display("test function done");
		// Middle hold asks for orderly shutdown; soft-off then forces the power role
		apb(1'b1, touch_key_pkg::OFS_CTRL, 32'h0);
		u_host.press(touch_key_pkg::KEY_MF, 40);
		chk(n_soft, 1);
		chk(n_hard, 0);
		apb(1'b1, touch_key_pkg::OFS_CTRL, 32'h1);
		while (host_s0 !== 1'b0)
			@(posedge clk);
		u_host.resp_dly = 2;
		repeat (8) @(posedge clk);
		u_host.press(touch_key_pkg::KEY_MF, 6);
		chk({led_mf, touch_en, n_pwr[0]}, 3'h2);
		u_host.press(touch_key_pkg::KEY_MF, 20);
		chk({touch_en, n_pwr[3:0]}, {1'b1, 4'h1});
		// Long hold forces shutdown while the key is still down, with nothing more on release
		while (host_s0 !== 1'b1)
			@(posedge clk);
		// Spare function code must also act as the power key
		apb(1'b1, touch_key_pkg::OFS_CTRL, 32'h3);
		repeat (8) @(posedge clk);
		u_host.press(touch_key_pkg::KEY_MF, 10);
		u_host.press(touch_key_pkg::KEY_MF, 100);
		chk({hard_held, n_hard[3:0], n_soft[3:0]}, {1'b1, 4'h1, 4'h1});
		// Every host-side event since the last clear is recorded
		apb(1'b0, touch_key_pkg::OFS_IRQ_STAT, 32'h0);
		chk(rd, 32'h1F);
		$display("test power done");
		finish_test();
	end
endmodule

`default_nettype wire
